// ==== ci2c_slave.v ====
`timescale 1ns/1ps
`include "ci2c_defines.vh"
module ci2c_slave (
  input wire clk_i,
  input wire rst_n_i,
  input wire scl_i,
  input wire sda_i,
  output wire scl_o,
  output wire scl_oe_o,
  output wire sda_o,
  output wire sda_oe_o,
  output reg [7:0] wr_addr_o,
  output reg [7:0] wr_data_o,
  output reg wr_en_o,
  output wire [7:0] rd_addr_o,
  input wire [7:0] rd_data_i,
  output reg hs_mode_o,
  output wire busy_o
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_ACK = 3'h2;
  localparam ST_PTR = 3'h3;
  localparam ST_WDAT = 3'h4;
  localparam ST_RDAT = 3'h5;
  localparam ST_RACK = 3'h6;

  wire scl_s;
  wire sda_s;
  wire scl_rise;
  wire scl_fall;
  wire start;
  wire stop;
  reg [2:0] state_reg;
  reg [2:0] after_reg; // state to enter once the ack slot ends
  reg [3:0] cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] ptr_reg;
  reg [7:0] tx_reg;
  reg drive_low_reg;
  reg ack_wr_reg; // this ack slot carries a data byte to store
  reg first_rd_reg;

  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  ci2c_sync u_sync_scl (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(scl_i),
    .q_o(scl_s)
  );
  ci2c_sync u_sync_sda (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(sda_i),
    .q_o(sda_s)
  );
  // oversampling at 250 MHz covers any bus rate to 400 kHz
  ci2c_cond u_cond (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .scl_i(scl_s),
    .sda_i(sda_s),
    .scl_rise_o(scl_rise),
    .scl_fall_o(scl_fall),
    .start_o(start),
    .stop_o(stop)
  );

  // clock line never driven: no stretching
  assign scl_o = 1'b0;
  assign scl_oe_o = 1'b0;
  // open drain: drive only a low, otherwise released
  assign sda_o = 1'b0;
  assign sda_oe_o = drive_low_reg;
  assign rd_addr_o = ptr_reg;
  assign busy_o = (state_reg != ST_IDLE);

  // ----------------------------------------
  // protocol engine
  // ----------------------------------------
  // bits are sampled on scl rise and the output changes on scl fall,
  // so the data line is steady for the whole high phase
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      after_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= `CI2C_PTR_RST;
      tx_reg <= 8'h00;
      drive_low_reg <= 1'b0;
      ack_wr_reg <= 1'b0;
      first_rd_reg <= 1'b0;
      wr_addr_o <= 8'h00;
      wr_data_o <= 8'h00;
      wr_en_o <= 1'b0;
      hs_mode_o <= `CI2C_HS_RST;
    end else begin
      wr_en_o <= 1'b0;
      if (stop) begin
        // stop frees the bus and restores standard filters
        state_reg <= ST_IDLE;
        drive_low_reg <= 1'b0;
        hs_mode_o <= `CI2C_HS_RST;
      end else if (start) begin
        // repeated start is the same as start; filter mode kept
        state_reg <= ST_ADDR;
        cnt_reg <= 4'h0;
        drive_low_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            // clock edges ignored until the next start
            drive_low_reg <= 1'b0;
          end
          ST_ADDR, ST_PTR, ST_WDAT: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s};
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == `CI2C_BITS) begin
              cnt_reg <= 4'h0;
              ack_wr_reg <= 1'b0;
              case (state_reg)
                ST_ADDR: begin
                  if (shift_reg[7:1] == `CI2C_SLAVE_ADDR) begin
                    drive_low_reg <= 1'b1;
                    state_reg <= ST_ACK;
                    after_reg <= shift_reg[0] ? ST_RDAT : ST_PTR;
                    first_rd_reg <= shift_reg[0];
                  end else begin
                    // master code switches filters, never acked
                    if (shift_reg[7:3] == `CI2C_HS_CODE) begin
                      hs_mode_o <= 1'b1;
                    end
                    // general call and foreign addresses are dropped
                    state_reg <= ST_IDLE;
                  end
                end
                ST_PTR: begin
                  ptr_reg <= shift_reg;
                  drive_low_reg <= 1'b1;
                  state_reg <= ST_ACK;
                  after_reg <= ST_WDAT;
                end
                default: begin
                  // every data byte acked, including the last
                  drive_low_reg <= 1'b1;
                  ack_wr_reg <= 1'b1;
                  state_reg <= ST_ACK;
                  after_reg <= ST_WDAT;
                end
              endcase
            end
          end
          ST_ACK: begin
            if (scl_rise && ack_wr_reg) begin
              // store lands at the acknowledge rising edge
              wr_addr_o <= ptr_reg;
              wr_data_o <= shift_reg;
              wr_en_o <= 1'b1;
              ptr_reg <= ptr_reg + 8'h01;
              ack_wr_reg <= 1'b0;
            end else if (scl_fall) begin
              drive_low_reg <= 1'b0;
              state_reg <= after_reg;
              cnt_reg <= 4'h0;
              if (after_reg == ST_RDAT) begin
                // first read bit goes out right after the ack
                tx_reg <= {rd_data_i[6:0], 1'b0};
                drive_low_reg <= ~rd_data_i[7];
                cnt_reg <= 4'h1;
              end
            end
          end
          ST_RDAT: begin
            if (scl_fall) begin
              if (cnt_reg == `CI2C_BITS) begin
                // release for the master's ack slot
                drive_low_reg <= 1'b0;
                ptr_reg <= ptr_reg + 8'h01;
                state_reg <= ST_RACK;
              end else begin
                drive_low_reg <= ~tx_reg[7];
                tx_reg <= {tx_reg[6:0], 1'b0};
                cnt_reg <= cnt_reg + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              // low means more bytes wanted, high ends the read
              first_rd_reg <= ~sda_s;
            end else if (scl_fall) begin
              if (first_rd_reg) begin
                tx_reg <= {rd_data_i[6:0], 1'b0};
                drive_low_reg <= ~rd_data_i[7];
                cnt_reg <= 4'h1;
                state_reg <= ST_RDAT;
              end else begin
                // nack: wait quietly for stop or repeated start
                state_reg <= ST_IDLE;
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // ci2c_slave

// ==== ci2c_defines.vh ====
`ifndef CI2C_DEFINES_VH
`define CI2C_DEFINES_VH
// 7-bit slave address 011 0101
`define CI2C_SLAVE_ADDR 7'h35
`define CI2C_ADDR_WR 8'h6A
`define CI2C_ADDR_RD 8'h6B
`define CI2C_GEN_CALL 8'h00
// bits per byte before the acknowledge slot
`define CI2C_BITS 4'h8
// reset value of the register pointer
`define CI2C_PTR_RST 8'h00
// reset value of the high-speed filter select
`define CI2C_HS_RST 1'b0
// high-speed master code pattern 0000 1xxx, upper five bits
`define CI2C_HS_CODE 5'h01
`endif

// ==== ci2c_sync.v ====
`timescale 1ns/1ps
// ----------------------------------------
// two-flop synchroniser for one pin input
// ----------------------------------------
module ci2c_sync (
  input wire clk_i,
  input wire rst_n_i,
  input wire d_i,
  output wire q_o
);
  reg meta_reg;
  reg sync_reg;
  // pins idle high, so reset to one to avoid a false start at release
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end else begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end
  assign q_o = sync_reg;
endmodule // ci2c_sync

// ==== ci2c_cond.v ====
`timescale 1ns/1ps
// ----------------------------------------
// edge and start/stop condition detector
// ----------------------------------------
module ci2c_cond (
  input wire clk_i,
  input wire rst_n_i,
  input wire scl_i,
  input wire sda_i,
  output wire scl_rise_o,
  output wire scl_fall_o,
  output wire start_o,
  output wire stop_o
);
  reg scl_reg;
  reg sda_reg;
  // previous samples of the synchronised lines
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      scl_reg <= scl_i;
      sda_reg <= sda_i;
    end
  end
  // data moving while clock high is a control condition only
  assign scl_rise_o = scl_i & ~scl_reg;
  assign scl_fall_o = ~scl_i & scl_reg;
  assign start_o = scl_i & scl_reg & sda_reg & ~sda_i;
  assign stop_o = scl_i & scl_reg & ~sda_reg & sda_i;
endmodule // ci2c_cond

// ==== ci2c_slave_sva.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// port checker for the slave
// ----------------------------------------
module ci2c_slave_sva (
  input wire clk_i,
  input wire rst_n_i,
  input wire scl_i,
  input wire sda_i,
  input wire scl_oe_o,
  input wire sda_oe_o,
  input wire wr_en_o,
  input wire hs_mode_o,
  input wire busy_o
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_scl_never_held: assert property (!scl_oe_o)
    else $error("clock line driven");
  a_wr_one_cycle: assert property (wr_en_o |=> !wr_en_o)
    else $error("store strobe too long");
  a_wr_in_ack: assert property (wr_en_o |-> scl_i && sda_oe_o)
    else $error("store outside acked clock high");
  a_idle_released: assert property (!busy_o |-> !sda_oe_o)
    else $error("data driven while idle");
  // the sync delay puts every drive change into the clock-low phase
  a_oe_steady_high: assert property (
    scl_i && $past(scl_i) |-> $stable(sda_oe_o))
    else $error("data drive moved while clock high");
  a_start_wakes: assert property (
    $fell(sda_i) && scl_i |-> ##[1:8] busy_o)
    else $error("start not seen");
  a_stop_idles: assert property (
    $rose(sda_i) && scl_i |-> ##[1:8] !busy_o)
    else $error("stop did not idle port");
  a_stop_hs_off: assert property (
    $rose(sda_i) && scl_i |-> ##[1:8] !hs_mode_o)
    else $error("stop kept fast filters");
  a_hs_no_ack: assert property ($rose(hs_mode_o) |-> !sda_oe_o)
    else $error("master code acknowledged");
  cover property (wr_en_o);
  cover property ($rose(hs_mode_o));
  cover property ($rose(sda_oe_o) && busy_o);
endmodule // ci2c_slave_sva
bind ci2c_slave ci2c_slave_sva chk_u (.clk_i, .rst_n_i, .scl_i, .sda_i,
  .scl_oe_o, .sda_oe_o, .wr_en_o, .hs_mode_o, .busy_o);

// ==== ci2c_mstr_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// bus master model, 160 ns bit time
// ----------------------------------------
module ci2c_mstr_model (
  input wire clk_i,
  input wire sda_i,
  output reg scl_o,
  output reg sda_low_o
);
  localparam int Q = 10; // quarter bit in clk cycles
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // start or repeated start, data falls with clock high
  task automatic start();
    sda_low_o = 1'b0;
    tick(Q);
    scl_o = 1'b1;
    tick(Q);
    sda_low_o = 1'b1;
    tick(Q);
    scl_o = 1'b0;
    tick(Q);
  endtask
  task automatic stop();
    sda_low_o = 1'b1;
    tick(Q);
    scl_o = 1'b1;
    tick(Q);
    sda_low_o = 1'b0;
    tick(Q);
  endtask
  // data moves only while clock low; one bit per clock
  task automatic bitx(input logic b, output logic r);
    sda_low_o = ~b;
    tick(Q);
    scl_o = 1'b1;
    tick(Q);
    r = sda_i;
    tick(Q);
    scl_o = 1'b0;
    tick(Q);
  endtask
  // eight bits msb first, then the ninth bit
  task automatic xfer(input logic [7:0] d, input logic nb,
    output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r[i]);
    end
    bitx(nb, a);
  endtask
endmodule // ci2c_mstr_model

// ==== tb_ci2c_slave.sv ====
`timescale 1ns/1ps
`include "ci2c_defines.vh"
module tb_ci2c_slave;
  // ----------------------------------------
  // bench wiring, open-drain bus levels
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] mem [0:255];
  logic [7:0] wr_addr, wr_data, rd_addr, r;
  logic wr_en, hs, busy, scl_oe, sda_oe, m_scl, m_sda, a;
  logic scl_d, sda_d;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_wr = 0;
  wire scl_w = m_scl & ~scl_oe;
  wire sda_w = ~(m_sda | sda_oe);
  always #2 clk_i = ~clk_i;
  ci2c_mstr_model m_u (.clk_i(clk_i), .sda_i(sda_w), .scl_o(m_scl),
    .sda_low_o(m_sda));
  ci2c_slave dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_w),
    .sda_i(sda_w), .scl_o(scl_d), .scl_oe_o(scl_oe), .sda_o(sda_d),
    .sda_oe_o(sda_oe), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
    .wr_en_o(wr_en), .rd_addr_o(rd_addr), .rd_data_i(mem[rd_addr]),
    .hs_mode_o(hs), .busy_o(busy));
  // register array stands in for the charger registers
  always @(posedge clk_i) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
      n_wr <= n_wr + 1;
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen,
    input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic snd(input logic [7:0] d, input logic nack);
    m_u.xfer(d, 1'b1, r, a);
    chk("ninth bit", {7'h00, a}, {7'h00, nack});
  endtask
  task automatic t_write();
    m_u.start();
    snd(`CI2C_ADDR_WR, 1'b0);
    snd(8'hFE, 1'b0);
    snd(8'hA5, 1'b0);
    snd(8'h3C, 1'b0);
    snd(8'hC3, 1'b0);
    m_u.stop();
    m_u.tick(8);
    chk("reg fe", mem[8'hFE], 8'hA5);
    chk("reg ff", mem[8'hFF], 8'h3C);
    chk("reg 00", mem[8'h00], 8'hC3);
    $display("write test done");
  endtask
  task automatic t_read();
    m_u.start();
    snd(`CI2C_ADDR_WR, 1'b0);
    snd(8'hFE, 1'b0);
    m_u.start();
    snd(`CI2C_ADDR_RD, 1'b0);
    m_u.xfer(8'hFF, 1'b0, r, a);
    chk("read 0", r, 8'hA5);
    m_u.xfer(8'hFF, 1'b0, r, a);
    chk("read 1", r, 8'h3C);
    m_u.xfer(8'hFF, 1'b1, r, a);
    chk("read 2", r, 8'hC3);
    m_u.stop();
    m_u.tick(8);
    chk("busy", {7'h00, busy}, 8'h00);
    $display("read test done");
  endtask
  // foreign address and general call: no ack, nothing stored
  task automatic t_refuse();
    int w;
    w = n_wr;
    for (int i = 0; i < 2; i++) begin
      m_u.start();
      snd(i ? `CI2C_GEN_CALL : 8'h6C, 1'b1);
      snd(8'h10, 1'b1);
      snd(8'h55, 1'b1);
      m_u.stop();
    end
    // retry with own address, then cut a data byte short by a stop
    m_u.start();
    snd(`CI2C_ADDR_WR, 1'b0);
    snd(8'h30, 1'b0);
    for (int i = 0; i < 4; i++) begin
      m_u.bitx(1'b1, a);
    end
    m_u.stop();
    m_u.tick(8);
    chk("stores", n_wr[7:0], w[7:0]);
    chk("abort busy", {7'h00, busy}, 8'h00);
    $display("refuse test done");
  endtask
  task automatic t_hs();
    chk("hs reset", {7'h00, hs}, 8'h00);
    chk("pin drive", {6'h00, scl_d, sda_d}, 8'h00);
    m_u.start();
    snd(8'h09, 1'b1);
    chk("hs set", {7'h00, hs}, 8'h01);
    m_u.start();
    snd(`CI2C_ADDR_WR, 1'b0);
    chk("hs kept", {7'h00, hs}, 8'h01);
    snd(8'h20, 1'b0);
    snd(8'h77, 1'b0);
    m_u.stop();
    m_u.tick(8);
    chk("hs clear", {7'h00, hs}, 8'h00);
    chk("reg 20", mem[8'h20], 8'h77);
    $display("hs test done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk_i);
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (4) @(negedge clk_i);
    rst_n_i = 1'b1;
    m_u.tick(4);
    t_hs();
    t_write();
    t_read();
    t_refuse();
    end_sim();
  end
endmodule // tb_ci2c_slave
